// [tcr_pkg.sv]
// shared constants and types of the thermocouple frame readout
package tcr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // frame layout
    localparam int FRAME_W = 32;
    localparam int TC_W = 14;
    localparam int TC_MSB = 31;
    localparam int TC_LSB = 18;
    localparam int RSV_HI_BIT = 17;
    localparam int FAULT_BIT = 16;
    localparam int CJ_W = 12;
    localparam int CJ_MSB = 15;
    localparam int CJ_LSB = 4;
    localparam int RSV_LO_BIT = 3;
    localparam int SCV_BIT = 2;
    localparam int SCG_BIT = 1;
    localparam int OC_BIT = 0;
    localparam int SHORT_READ_BITS = 14;
    localparam int FULL_READ_BITS = 32;
    localparam logic [31:0] FRAME_RST = 32'h0000_0000;
    localparam logic [13:0] TC_OPEN_CODE = 14'h1FFF;
    localparam logic [13:0] TC_POS_LIMIT = 14'h1FFF;
    localparam logic [13:0] TC_NEG_LIMIT = 14'h2000;

    ////////////////////////////////////////////////////////////////////////
    // conversion arithmetic
    localparam int ADC_W = 18;
    localparam int TC_GAIN_NV = 41276;
    localparam int RECIP_SHIFT = 16;
    // quarter degrees per microvolt, scaled by 2**RECIP_SHIFT
    localparam int TC_RECIP =
        (4 * 1000 * (1 << RECIP_SHIFT) + TC_GAIN_NV / 2) / TC_GAIN_NV;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int MCLK_PERIOD_NS = 8;
    localparam int CONV_PERIOD_MS = 70;
    localparam int CONV_CYCLES =
        CONV_PERIOD_MS * (1000000 / MCLK_PERIOD_NS);
    localparam int PHASE_CYCLES = CONV_CYCLES / 3;
    localparam int SCK_HALF_NS = 100;
    localparam int CSS_NS = 100;
    localparam int CS_HOLD_NS = 100;
    localparam int CS_IDLE_NS = 200;
    localparam int SCK_HALF_CYC =
        (SCK_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int CSS_CYC = (CSS_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int CS_HOLD_CYC =
        (CS_HOLD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int CS_IDLE_CYC =
        (CS_IDLE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // sequencer phases and switch sets {S5, S4, S3, S2, S1}
    typedef enum logic [1:0] {
        PH_CJ = 2'h0,
        PH_TC = 2'h1,
        PH_FAULT = 2'h3
    } tcr_phase_t;

    localparam logic [4:0] SW_SET_CJ = 5'h14;
    localparam logic [4:0] SW_SET_TC = 5'h0C;
    localparam logic [4:0] SW_SET_FAULT = 5'h03;

    ////////////////////////////////////////////////////////////////////////
    // host read sequencer
    typedef enum logic [2:0] {
        M_IDLE = 3'h0,
        M_SETUP = 3'h1,
        M_HIGH = 3'h3,
        M_LOW = 3'h2,
        M_HOLD = 3'h6,
        M_GAP = 3'h7
    } tcr_mst_t;

endpackage

// [tcr_link_if.sv]
// serial link between the converter and its host
`timescale 1ns/1ps
interface tcr_link_if;
    logic sck;
    logic cs_n;
    logic so_o;
    logic so_oe;
    logic so;

    // released line idles low, as through a pull-down
    assign so = so_oe ? so_o : 1'b0;

    modport dev (
        input sck,
        input cs_n,
        output so_o,
        output so_oe
    );

    modport host (
        output sck,
        output cs_n,
        input so
    );
endinterface // tcr_link_if

// [tcr_sync.sv]
// three-stage synchroniser with agreement filter for one asynchronous bit
`timescale 1ns/1ps
module tcr_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // data
    input wire logic din,
    output logic dout
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
            s3_ff <= RST_VAL;
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dout <= RST_VAL;
        end else if (s2_ff == s3_ff) begin
            dout <= s3_ff;
        end
    end
endmodule // tcr_sync

// [tcr_device.sv]
// converter end: conversion sequencer, result frame and serial readout
`timescale 1ns/1ps
module tcr_device #(
    parameter int unsigned PHASE_CYCLES = tcr_pkg::PHASE_CYCLES,
    parameter int unsigned ADC_W = tcr_pkg::ADC_W
) (
    // system
    input wire logic MCLK,
    input wire logic RESET,
    // analog front end results
    input wire logic [ADC_W-1:0] ADC_DATA,
    input wire logic FLT_SUPPLY,
    input wire logic FLT_GROUND,
    input wire logic FLT_OPEN,
    // front-end switch controls, high closes the switch
    output logic SW_FAULT_P,
    output logic SW_FAULT_N,
    output logic SW_GND_REF,
    output logic SW_TC_ADC,
    output logic SW_CJ_ADC,
    output tcr_pkg::tcr_phase_t PHASE,
    output logic RESULT_VALID,
    // serial link
    tcr_link_if.dev LINK
);
    import tcr_pkg::*;

    localparam int PW = (PHASE_CYCLES > 1) ? $clog2(PHASE_CYCLES) : 1;

    generate
        if (PHASE_CYCLES < 2) begin : g_bad_phase
            $error("PHASE_CYCLES must be at least 2");
        end
        if (ADC_W < CJ_W || ADC_W > 19) begin : g_bad_adc
            $error("ADC_W must lie between CJ_W and 19");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // helper functions

    function automatic logic [4:0] switch_set(input tcr_phase_t ph);
        case (ph)
            PH_CJ: switch_set = SW_SET_CJ;
            PH_TC: switch_set = SW_SET_TC;
            PH_FAULT: switch_set = SW_SET_FAULT;
            default: switch_set = SW_SET_CJ;
        endcase
    endfunction

    // microvolts to quarter degrees through a fixed-point reciprocal
    function automatic logic signed [15:0] uv_to_quarter(
        input logic [ADC_W-1:0] uv
    );
        logic signed [31:0] wide;
        logic signed [31:0] prod;
        wide = $signed({{(32 - ADC_W){uv[ADC_W-1]}}, uv});
        prod = wide * $signed(32'(TC_RECIP));
        uv_to_quarter = 16'(prod >>> RECIP_SHIFT);
    endfunction

    function automatic logic [TC_W-1:0] sat_tc(input logic signed [15:0] v);
        if (v > $signed(16'h1FFF)) begin
            sat_tc = TC_POS_LIMIT;
        end else if (v < $signed(16'hE000)) begin
            sat_tc = TC_NEG_LIMIT;
        end else begin
            sat_tc = v[TC_W-1:0];
        end
    endfunction

    function automatic logic [FRAME_W-1:0] build_frame(
        input logic [TC_W-1:0] tc,
        input logic [CJ_W-1:0] cj,
        input logic [2:0] flt
    );
        logic [FRAME_W-1:0] f;
        f = FRAME_RST;
        f[TC_MSB:TC_LSB] = tc;
        f[RSV_HI_BIT] = 1'b0;
        f[FAULT_BIT] = |flt;
        f[CJ_MSB:CJ_LSB] = cj;
        f[RSV_LO_BIT] = 1'b0;
        f[SCV_BIT] = flt[2];
        f[SCG_BIT] = flt[1];
        f[OC_BIT] = flt[0];
        build_frame = f;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // conversion sequencer, free running whatever the link does

    logic [PW-1:0] phase_cnt_ff;
    tcr_phase_t phase_ff;
    tcr_phase_t nxt_phase;
    logic phase_end;

    assign phase_end = (phase_cnt_ff == PW'(PHASE_CYCLES - 1));

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            phase_cnt_ff <= '0;
        end else if (phase_end) begin
            phase_cnt_ff <= '0;
        end else begin
            phase_cnt_ff <= phase_cnt_ff + PW'(1);
        end
    end

    always_comb begin
        case (phase_ff)
            PH_CJ: nxt_phase = PH_TC;
            PH_TC: nxt_phase = PH_FAULT;
            PH_FAULT: nxt_phase = PH_CJ;
            default: nxt_phase = PH_CJ;
        endcase
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            phase_ff <= PH_CJ;
        end else if (phase_end) begin
            phase_ff <= nxt_phase;
        end
    end

    assign PHASE = phase_ff;

    // switches follow the phase register edge for edge
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            {SW_CJ_ADC, SW_TC_ADC, SW_GND_REF, SW_FAULT_N, SW_FAULT_P}
                <= SW_SET_CJ;
        end else begin
            {SW_CJ_ADC, SW_TC_ADC, SW_GND_REF, SW_FAULT_N, SW_FAULT_P}
                <= switch_set(phase_end ? nxt_phase : phase_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result capture at the end of each phase

    logic [CJ_W-1:0] cj_ff;
    logic signed [15:0] tc_raw_ff;
    logic [FRAME_W-1:0] result_ff;
    logic signed [15:0] hot_sum;
    logic [2:0] flt_now;

    assign flt_now = {FLT_SUPPLY, FLT_GROUND, FLT_OPEN};
    // die temperature in sixteenths brought to quarter degrees
    assign hot_sum = tc_raw_ff
        + $signed({{6{cj_ff[CJ_W-1]}}, cj_ff[CJ_W-1:2]});

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            cj_ff <= '0;
        end else if (phase_end && phase_ff == PH_CJ) begin
            cj_ff <= ADC_DATA[CJ_W-1:0];
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            tc_raw_ff <= '0;
        end else if (phase_end && phase_ff == PH_TC) begin
            tc_raw_ff <= uv_to_quarter(ADC_DATA);
        end
    end

    // a full period is complete once fault detection has run
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            result_ff <= FRAME_RST;
            RESULT_VALID <= 1'b0;
        end else if (phase_end && phase_ff == PH_FAULT) begin
            RESULT_VALID <= 1'b1;
            if (FLT_OPEN) begin
                result_ff <= build_frame(TC_OPEN_CODE, cj_ff, flt_now);
            end else begin
                result_ff <= build_frame(sat_tc(hot_sum), cj_ff, flt_now);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // frame hold, refreshed only while the link is idle

    logic cs_idle;
    logic [FRAME_W-1:0] frame_hold_ff;

    tcr_sync #(
        .RST_VAL(1'b1)
    ) u_cs_sync (
        .clk(MCLK),
        .rst(RESET),
        .din(LINK.cs_n),
        .dout(cs_idle)
    );

    // the hold word is quasi-static during a read, so the link side may
    // read it directly; a refresh racing the select fall lands inside
    // the setup time the host must leave before its first clock edge
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            frame_hold_ff <= FRAME_RST;
        end else if (cs_idle) begin
            frame_hold_ff <= result_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link side, clocked by the serial clock

    logic [5:0] bit_idx_ff;

    // select high clears the index at once, so an early end needs no
    // clock edge and the next read starts from the sign bit again
    always_ff @(negedge LINK.sck or posedge LINK.cs_n) begin
        if (LINK.cs_n) begin
            bit_idx_ff <= '0;
        end else if (bit_idx_ff != 6'(FRAME_W)) begin
            bit_idx_ff <= bit_idx_ff + 6'h01;
        end
    end

    // index zero shows the sign bit as soon as select falls
    assign LINK.so_o = (bit_idx_ff < 6'(FRAME_W))
        ? frame_hold_ff[~bit_idx_ff[4:0]] : 1'b0;
    assign LINK.so_oe = ~LINK.cs_n;

endmodule // tcr_device

// [tcr_host.sv]
// host end: select and serial clock generation, frame capture
`timescale 1ns/1ps
module tcr_host #(
    parameter int unsigned SCK_HALF = tcr_pkg::SCK_HALF_CYC,
    parameter int unsigned CSS = tcr_pkg::CSS_CYC,
    parameter int unsigned CS_HOLD = tcr_pkg::CS_HOLD_CYC,
    parameter int unsigned CS_IDLE = tcr_pkg::CS_IDLE_CYC
) (
    // system
    input wire logic MCLK,
    input wire logic RESET,
    // user request
    input wire logic START,
    input wire logic FULL_READ,
    input wire logic ABORT,
    // user answer
    output logic BUSY,
    output logic DONE,
    output logic [tcr_pkg::FRAME_W-1:0] FRAME,
    output logic [5:0] BITS_READ,
    // serial link
    tcr_link_if.host LINK
);
    import tcr_pkg::*;

    generate
        if (SCK_HALF < 1 || CSS < 1 || CS_HOLD < 1 || CS_IDLE < 1 ||
            SCK_HALF > 255 || CSS > 255 || CS_HOLD > 255 ||
            CS_IDLE > 255) begin : g_bad_timing
            $error("host timing counts must lie between 1 and 255");
        end
    endgenerate

    tcr_mst_t state_ff;
    tcr_mst_t nxt_state;
    logic [7:0] timer_ff;
    logic [7:0] nxt_timer;
    logic [5:0] cnt_ff;
    logic [5:0] nbits_ff;
    logic [FRAME_W-1:0] shift_ff;
    logic so_s;
    logic tdone;
    logic sample;
    logic last_bit;

    tcr_sync #(
        .RST_VAL(1'b0)
    ) u_so_sync (
        .clk(MCLK),
        .rst(RESET),
        .din(LINK.so),
        .dout(so_s)
    );

    assign tdone = (timer_ff == 8'h00);
    assign sample = (state_ff == M_HIGH) && tdone;
    assign last_bit = ((cnt_ff + 6'h01) == nbits_ff);

    ////////////////////////////////////////////////////////////////////////
    // read sequencer

    always_comb begin
        nxt_state = state_ff;
        nxt_timer = tdone ? 8'h00 : timer_ff - 8'h01;
        case (state_ff)
            M_IDLE: begin
                if (START) begin
                    nxt_state = M_SETUP;
                    nxt_timer = 8'(CSS - 1);
                end
            end
            M_SETUP, M_LOW: begin
                if (ABORT) begin
                    nxt_state = M_HOLD;
                    nxt_timer = 8'(CS_HOLD - 1);
                end else if (tdone) begin
                    nxt_state = M_HIGH;
                    nxt_timer = 8'(SCK_HALF - 1);
                end
            end
            M_HIGH: begin
                if (tdone && (last_bit || ABORT)) begin
                    nxt_state = M_HOLD;
                    nxt_timer = 8'(CS_HOLD - 1);
                end else if (tdone) begin
                    nxt_state = M_LOW;
                    nxt_timer = 8'(SCK_HALF - 1);
                end
            end
            M_HOLD: begin
                if (tdone) begin
                    nxt_state = M_GAP;
                    nxt_timer = 8'(CS_IDLE - 1);
                end
            end
            M_GAP: begin
                if (tdone) begin
                    nxt_state = M_IDLE;
                end
            end
            default: begin
                nxt_state = M_IDLE;
                nxt_timer = 8'h00;
            end
        endcase
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            state_ff <= M_IDLE;
            timer_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            timer_ff <= nxt_timer;
        end
    end

    // pins come from flops decoded from the next state
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            LINK.sck <= 1'b0;
            LINK.cs_n <= 1'b1;
            BUSY <= 1'b0;
        end else begin
            LINK.sck <= (nxt_state == M_HIGH);
            LINK.cs_n <= (nxt_state == M_IDLE) || (nxt_state == M_GAP);
            BUSY <= (nxt_state != M_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bit capture: sample just before the falling edge, long after the
    // converter moved its output on the previous fall

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            shift_ff <= FRAME_RST;
            cnt_ff <= 6'h00;
            nbits_ff <= 6'(FULL_READ_BITS);
        end else if (state_ff == M_IDLE && START) begin
            shift_ff <= FRAME_RST;
            cnt_ff <= 6'h00;
            nbits_ff <= FULL_READ ? 6'(FULL_READ_BITS)
                                  : 6'(SHORT_READ_BITS);
        end else if (sample) begin
            shift_ff[~cnt_ff[4:0]] <= so_s;
            cnt_ff <= cnt_ff + 6'h01;
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            DONE <= 1'b0;
            FRAME <= FRAME_RST;
            BITS_READ <= 6'h00;
        end else begin
            DONE <= (state_ff == M_GAP) && tdone;
            if ((state_ff == M_GAP) && tdone) begin
                FRAME <= shift_ff;
                BITS_READ <= cnt_ff;
            end
        end
    end

endmodule // tcr_host

// [tcr_link_checker.sv]
// assertions on the serial link between converter and host
`timescale 1ns/1ps
module tcr_link_checker (
    // system
    input wire logic MCLK,
    input wire logic RESET,
    // link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic so_o,
    input wire logic so_oe,
    input wire logic so
);
    logic sck_ff;
    logic [6:0] cnt_ff;
    logic [3:0] low_ff;
    logic fell_now;
    logic [6:0] idx;

    ////////////////////////////////////////////////////////////////////////
    // bit index as seen on the wire, counted in the system clock
    assign fell_now = sck_ff & ~sck;
    assign idx = cnt_ff + {6'h00, fell_now};

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET)
            sck_ff <= 1'b0;
        else
            sck_ff <= sck;
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET)
            cnt_ff <= 7'h00;
        else if (cs_n)
            cnt_ff <= 7'h00;
        else
            cnt_ff <= idx;
    end

    // frame copy may still land a few cycles after select falls
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET)
            low_ff <= 4'h0;
        else if (cs_n)
            low_ff <= 4'h0;
        else if (low_ff != 4'hF)
            low_ff <= low_ff + 4'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);

    a_oe_follows_select: assert property (so_oe == !cs_n)
        else $error("output enable does not follow select");
    a_line_carries_data: assert property (so_oe |-> so == so_o)
        else $error("line does not carry device data");
    a_bit_moves_on_fall: assert property (
        (!cs_n && low_ff > 4'h7 && !fell_now) |-> $stable(so))
        else $error("data changed without a clock fall");
    a_reserved_bits_zero: assert property (
        (!cs_n && (idx == 7'h0E || idx == 7'h1C)) |-> !so)
        else $error("reserved bit not zero");
    a_clock_count_limit: assert property (idx <= 7'h20)
        else $error("more than a full frame clocked");
    a_no_clock_idle: assert property (cs_n |-> !sck)
        else $error("clock high while deselected");
    a_select_setup: assert property ($fell(cs_n) |-> !sck [*8])
        else $error("clock rose too soon after select");
    a_clock_high_width: assert property ($rose(sck) |-> sck [*8])
        else $error("clock high phase too short");

    c_full_frame: cover property (!cs_n && idx == 7'h20);
    c_short_read: cover property ($rose(cs_n) && cnt_ff == 7'h0E);
    c_abort_mid: cover property ($rose(cs_n) && cnt_ff < 7'h0E);
endmodule // tcr_link_checker

// [test_thermocouple_frame_readout.sv]
// self-checking bench joining converter and host across the link
`timescale 1ns/1ps
module test_thermocouple_frame_readout;
    import tcr_pkg::*;
    localparam int PH_CYC = 20;
    localparam int LIMIT = 40000;
    logic mclk, reset, start, full_read, abort, busy, done, valid;
    logic flt_supply, flt_ground, flt_open;
    logic sw_p, sw_n, sw_g, sw_t, sw_c;
    logic [17:0] adc_data, uv_v;
    logic [11:0] die_v;
    logic [31:0] frame, m_exp, m_mask;
    logic [5:0] bits_read;
    tcr_phase_t phase, prev_ph;
    logic [31:0] exp_q[$];
    int bits_q[$];
    logic abort_q[$];
    logic m_ab;
    int m_bits, mismatches, samples_checked, cycles;

    tcr_link_if link ();
    tcr_device #(.PHASE_CYCLES(PH_CYC)) tcr_device_i (.MCLK(mclk),
        .RESET(reset), .ADC_DATA(adc_data), .FLT_SUPPLY(flt_supply),
        .FLT_GROUND(flt_ground), .FLT_OPEN(flt_open), .SW_FAULT_P(sw_p),
        .SW_FAULT_N(sw_n), .SW_GND_REF(sw_g), .SW_TC_ADC(sw_t),
        .SW_CJ_ADC(sw_c), .PHASE(phase), .RESULT_VALID(valid),
        .LINK(link.dev));
    tcr_host tcr_host_i (.MCLK(mclk), .RESET(reset), .START(start),
        .FULL_READ(full_read), .ABORT(abort), .BUSY(busy), .DONE(done),
        .FRAME(frame), .BITS_READ(bits_read), .LINK(link.host));
    tcr_link_checker tcr_link_checker_i (.MCLK(mclk), .RESET(reset),
        .sck(link.sck), .cs_n(link.cs_n), .so_o(link.so_o),
        .so_oe(link.so_oe), .so(link.so));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic fail(input string msg);
        mismatches++;
        $display("ERROR t=%0t %s", $time, msg);
    endtask

    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1)
            fail(msg);
    endtask

    task tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // open input overrides the temperature; shorts leave it alone
    function automatic logic [31:0] exp_frame(input logic [11:0] die,
        input logic [17:0] uv, input logic [2:0] f);
        int t;
        t = ((int'($signed(uv)) * TC_RECIP) >>> 16)
            + (int'($signed(die)) >>> 2);
        if (f[0])
            t = 32'h0000_1FFF;
        return {t[13:0], 1'b0, |f, die, 1'b0, f};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // the adc port carries die or thermocouple data by phase
    always @(posedge mclk)
        adc_data <= (phase === PH_CJ) ? {6'h00, die_v} : uv_v;

    task automatic do_read(input logic full, input int ab,
        input logic [2:0] f);
        logic [31:0] e;
        die_v <= 12'($urandom);
        uv_v <= 18'($urandom_range(32'h186A0)) - 18'h0C350;
        {flt_supply, flt_ground, flt_open} <= f;
        repeat (200) @(posedge mclk);
        e = exp_frame(die_v, uv_v, f);
        if (!full)
            e = e & 32'hFFFC_0000;
        exp_q.push_back(e);
        bits_q.push_back(full ? 32 : 14);
        abort_q.push_back(ab != 0);
        start <= 1'b1;
        full_read <= full;
        @(posedge mclk);
        start <= 1'b0;
        // new inputs mid-read must not reach this frame
        repeat (10) @(posedge mclk);
        chk(busy === 1'b1 && link.cs_n === 1'b0, "read not under way");
        die_v <= ~die_v;
        uv_v <= uv_v ^ 18'h00155;
        {flt_supply, flt_ground, flt_open} <= ~f;
        if (ab != 0) begin
            repeat (ab) @(posedge mclk);
            abort <= 1'b1;
        end
        do @(posedge mclk); while (done !== 1'b1);
        abort <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge mclk) begin
        if (!reset && done === 1'b1) begin
            if (exp_q.size() == 0) begin
                fail("completion with nothing expected");
            end else begin
                m_exp = exp_q.pop_front();
                m_bits = bits_q.pop_front();
                m_ab = abort_q.pop_front();
                chk(valid === 1'b1 && busy === 1'b0, "status at end");
                m_mask = ~(32'hFFFF_FFFF >> bits_read);
                if (m_ab) begin
                    chk(bits_read < 6'(m_bits), "abort ignored");
                    chk((frame & m_mask) === (m_exp & m_mask), "abort data");
                end else begin
                    chk(bits_read === 6'(m_bits), "bit count");
                    chk(frame === m_exp, "frame mismatch");
                end
            end
        end
    end

    always @(posedge mclk) begin
        if (!reset) begin
            case (phase)
                PH_CJ: chk({sw_c, sw_t, sw_g, sw_n, sw_p} === 5'h14, "cj switches");
                PH_TC: chk({sw_c, sw_t, sw_g, sw_n, sw_p} === 5'h0C, "tc switches");
                default: chk({sw_c, sw_t, sw_g, sw_n, sw_p} === 5'h03, "fault switches");
            endcase
            if (phase !== prev_ph)
                chk(phase === ((prev_ph == PH_CJ) ? PH_TC : (prev_ph == PH_TC) ? PH_FAULT : PH_CJ), "phase order");
            prev_ph = phase;
        end
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail("run did not finish in time");
            tally_and_finish();
        end
    end

    initial begin
        void'($urandom(32'hDF59C1FF));
        reset = 1'b1;
        start = 1'b0;
        full_read = 1'b0;
        abort = 1'b0;
        flt_supply = 1'b0;
        flt_ground = 1'b0;
        flt_open = 1'b0;
        die_v = 12'h000;
        uv_v = 18'h00000;
        prev_ph = PH_CJ;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        for (int i = 0; i < 8; i++)
            do_read(1'b1, 0, 3'(i));
        do_read(1'b0, 0, 3'h0);
        do_read(1'b0, 0, 3'h2);
        do_read(1'b1, 300, 3'h0);
        do_read(1'b1, 0, 3'h4);
        repeat (5) @(posedge mclk);
        tally_and_finish();
    end
endmodule // test_thermocouple_frame_readout
